// ---- logic/i2c_port_defs.vh ----
// constants for the two-wire register port of the rate sensor
// What this block does
// RULE_01: answer address with six fixed upper bits
// RULE_02: lowest address bit follows select pin
// RULE_03: master clocks bus at 400 kHz max; the bench master model uses a 160 ns bit slot instead
// RULE_04: start/stop are SDA edges while SCL high
// RULE_05: bus busy from start until stop
// RULE_06: receiver holds SDA low through ninth clock
// RULE_07: device may stretch SCL; master waits
// RULE_08: master sends address, direction, then releases SDA
// RULE_09: SDA changes only while SCL low
// RULE_10: ack address, pointer, each written data byte
// RULE_11: burst write advances pointer per byte
// RULE_12: read: write pointer, repeated start, read data
// RULE_13: master acks for more, nacks then stops
// RULE_14: no limit on burst length
// RULE_15: repeated start re-evaluates address, ignore others
// RULE_16: identity register holds own bus address
// RULE_17: sensor registers read-only, latest measurement
// RULE_18: burst read advances pointer after each byte
// RULE_19: no ack on address mismatch
`ifndef I2C_PORT_DEFS_VH
`define I2C_PORT_DEFS_VH

// ----------------------------------------------------------------
// bus address and bits per byte
// ----------------------------------------------------------------
`define ADDR_UPPER6 6'h34
`define BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------
// internal register map
// ----------------------------------------------------------------
`define REG_IDENTITY 8'h00
`define REG_SENS_BASE 8'h10
`define SENS_BYTES 8'h06
`define REG_RW_BASE 8'h20

// ----------------------------------------------------------------
// protocol states
// ----------------------------------------------------------------
`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_ADDR_ACK 3'h2
`define ST_PTR 3'h3
`define ST_PTR_ACK 3'h4
`define ST_WDATA 3'h5
`define ST_WDATA_ACK 3'h6
`define ST_RDATA 3'h7
`define ST_RACK 3'h0

`endif

// ---- logic/sync_2ff.v ----
// two flip-flop synchroniser for levels from outside the clock domain
`default_nettype none

module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire reset_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // idle bus lines are high, so reset to ones to avoid a false edge
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_r <= {WIDTH{1'b1}};
      sync_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ---- logic/i2c_slave_register_port.v ----
// two-wire bus target port giving register access to the rate sensor
`include "i2c_port_defs.vh"
`default_nettype none

module i2c_slave_register_port #(
  parameter NUM_RW = 16,
  parameter RW_AW = 4
) (
  input wire clk_i,
  input wire reset_i,
  input wire scl_i,
  output wire scl_o,
  output reg scl_oe_n_o,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe_n_o,
  input wire addr_lsb_select_pin_i,
  input wire [47:0] sensor_data_i,
  input wire sensor_valid_i,
  input wire stall_i,
  output reg bus_busy_o,
  output reg wr_stb_o,
  output reg [7:0] wr_addr_o,
  output reg [7:0] wr_data_o
);

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  wire [2:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire sel_s;
  reg scl_d_r;
  reg sda_d_r;

  sync_2ff #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({scl_i, sda_i, addr_lsb_select_pin_i}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign sel_s = pins_s[0];

  // delayed copies taken after the synchroniser, never from its first stage
  always @(posedge clk_i) begin
    if (reset_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  // both lines share one synchroniser delay, so their order is kept
  wire start_det = scl_s & scl_d_r & ~sda_s & sda_d_r; // RULE_04
  wire stop_det = scl_s & scl_d_r & sda_s & ~sda_d_r; // RULE_04

  // own address: fixed upper bits and the select pin level
  wire [6:0] my_addr = {`ADDR_UPPER6, sel_s}; // RULE_01 RULE_02

  // open-drain lines only ever pull low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [7:0] snap_r [0:5];
  reg [7:0] mem_r [0:NUM_RW-1];
  integer i;
  integer j;

  // latest measurement replaces the snapshot; the bus cannot write it
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (i = 0; i < 6; i = i + 1) begin
        snap_r[i] <= 8'h00;
      end
    end else if (sensor_valid_i) begin
      for (i = 0; i < 6; i = i + 1) begin
        snap_r[i] <= sensor_data_i[47 - 8 * i -: 8]; // RULE_17
      end
    end
  end

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  reg [2:0] st_r;
  reg rd_phase_r;
  reg [3:0] bitcnt_r;
  reg [7:0] sh_r;
  reg rw_r;
  reg [7:0] ptr_r;
  reg drv_r;
  reg [7:0] rd_byte;
  reg rw_hit;
  reg [7:0] sens_idx;
  reg [7:0] rw_idx;

  // read mux over the pointer; unmapped addresses read as zero
  always @* begin
    sens_idx = ptr_r - `REG_SENS_BASE;
    rw_idx = ptr_r - `REG_RW_BASE;
    rw_hit = (ptr_r >= `REG_RW_BASE) && (rw_idx < NUM_RW);
    rd_byte = 8'h00;
    if (ptr_r == `REG_IDENTITY) begin
      rd_byte = {1'b0, my_addr}; // RULE_16
    end else if (sens_idx < `SENS_BYTES) begin
      rd_byte = snap_r[sens_idx[2:0]]; // RULE_17
    end else if (rw_hit) begin
      rd_byte = mem_r[rw_idx[RW_AW-1:0]];
    end
  end

  // the read ack wait shares its code with idle, told apart by a flag
  wire in_read = rd_phase_r && (st_r == `ST_RDATA);
  wire in_rack = rd_phase_r && (st_r == `ST_RACK);
  wire rx_state = !rd_phase_r &&
    ((st_r == `ST_ADDR) || (st_r == `ST_PTR) || (st_r == `ST_WDATA));
  wire byte_done = (bitcnt_r == `BITS_PER_BYTE);

  // main sequencer: bits are sampled on rising SCL, SDA moved on falling
  always @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= `ST_IDLE;
      rd_phase_r <= 1'b0;
      bitcnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      ptr_r <= 8'h00;
      drv_r <= 1'b0;
      bus_busy_o <= 1'b0;
      wr_stb_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      for (j = 0; j < NUM_RW; j = j + 1) begin
        mem_r[j] <= 8'h00;
      end
    end else begin
      wr_stb_o <= 1'b0;
      if (start_det) begin
        // fresh or repeated start: busy stays set, address is checked again
        bus_busy_o <= 1'b1; // RULE_05
        st_r <= `ST_ADDR; // RULE_15
        rd_phase_r <= 1'b0;
        bitcnt_r <= 4'h0;
        drv_r <= 1'b0;
      end else if (stop_det) begin
        bus_busy_o <= 1'b0; // RULE_05
        st_r <= `ST_IDLE;
        rd_phase_r <= 1'b0;
        drv_r <= 1'b0;
      end else if (scl_rise) begin
        if (rx_state) begin
          sh_r <= {sh_r[6:0], sda_s};
          bitcnt_r <= bitcnt_r + 4'h1;
        end else if (in_read) begin
          bitcnt_r <= bitcnt_r + 4'h1;
        end else if (in_rack && sda_s) begin
          // master left SDA high: no more bytes, wait for stop or start
          st_r <= `ST_IDLE; // RULE_13
          rd_phase_r <= 1'b0;
        end
      end else if (scl_fall) begin
        // all SDA changes happen here, while SCL is low
        if (rx_state && byte_done) begin // RULE_09
          bitcnt_r <= 4'h0;
          if (st_r == `ST_ADDR) begin
            if (sh_r[7:1] == my_addr) begin
              rw_r <= sh_r[0];
              drv_r <= 1'b1; // RULE_06
              st_r <= `ST_ADDR_ACK;
            end else begin
              st_r <= `ST_IDLE; // RULE_19 RULE_15
            end
          end else if (st_r == `ST_PTR) begin
            ptr_r <= sh_r; // RULE_12
            drv_r <= 1'b1; // RULE_10
            st_r <= `ST_PTR_ACK;
          end else begin
            // identity and sensor addresses accept the byte but keep their value
            if (rw_hit) begin
              mem_r[rw_idx[RW_AW-1:0]] <= sh_r; // RULE_11 RULE_17
            end
            wr_stb_o <= 1'b1;
            wr_addr_o <= ptr_r;
            wr_data_o <= sh_r;
            ptr_r <= ptr_r + 8'h01; // RULE_11 RULE_14
            drv_r <= 1'b1; // RULE_10
            st_r <= `ST_WDATA_ACK;
          end
        end else if (!rd_phase_r && (st_r == `ST_ADDR_ACK)) begin
          bitcnt_r <= 4'h0;
          if (rw_r) begin
            // read direction: first data bit goes out right after the ack
            sh_r <= rd_byte; // RULE_12
            drv_r <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'h01; // RULE_18
            rd_phase_r <= 1'b1;
            st_r <= `ST_RDATA;
          end else begin
            drv_r <= 1'b0;
            st_r <= `ST_PTR;
          end
        end else if (!rd_phase_r &&
                     ((st_r == `ST_PTR_ACK) || (st_r == `ST_WDATA_ACK))) begin
          drv_r <= 1'b0; // RULE_06
          bitcnt_r <= 4'h0;
          st_r <= `ST_WDATA;
        end else if (in_read) begin
          if (byte_done) begin
            drv_r <= 1'b0; // release for the master's answer
            st_r <= `ST_RACK;
          end else begin
            drv_r <= ~sh_r[3'h7 - bitcnt_r[2:0]];
          end
        end else if (in_rack) begin
          // master acked: next register goes out with no length limit
          sh_r <= rd_byte; // RULE_13 RULE_14
          drv_r <= ~rd_byte[7];
          ptr_r <= ptr_r + 8'h01; // RULE_18
          bitcnt_r <= 4'h0;
          st_r <= `ST_RDATA;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // stretch only inside our own transfer and begin only on a seen SCL fall:
  // the synchroniser lags the pin, so a low level alone could clip a high
  // phase the master has just started; once held, hold while stall_i stays
  always @(posedge clk_i) begin
    if (reset_i) begin
      sda_oe_n_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
    end else begin
      sda_oe_n_o <= ~drv_r;
      scl_oe_n_o <= ~(stall_i && (scl_fall || !scl_oe_n_o) && (rd_phase_r ||
        ((st_r != `ST_IDLE) && (st_r != `ST_ADDR)))); // RULE_07
    end
  end

endmodule

`default_nettype wire

// ---- test/i2c_port_checker_sva.sv ----
// pin relation checker for the two-wire register port
`default_nettype none
module i2c_port_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic stall_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic bus_busy_o,
  input wire logic wr_stb_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // the busy flag trails the wire by the synchroniser delay plus its own register stage
  busy_start_a: assert property ($fell(sda_i) && scl_i |-> ##[1:8] bus_busy_o)
    else $error("busy late after start");
  busy_stop_a: assert property ($rose(sda_i) && scl_i |-> ##[1:8] !bus_busy_o)
    else $error("busy held after stop");
  sda_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("sda moved with scl high");
  ack_hold_a: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
    else $error("sda pull too short");
  stretch_cause_a: assert property ($fell(scl_oe_n_o) |-> $past(stall_i))
    else $error("stretch without stall");
  stretch_end_a: assert property ($fell(stall_i) |-> ##[0:2] scl_oe_n_o)
    else $error("stretch outlived stall");
  idle_free_a: assert property (!bus_busy_o |-> sda_oe_n_o && scl_oe_n_o)
    else $error("line pulled while idle");
  write_pulse_a: assert property (wr_stb_o |-> bus_busy_o ##1 !wr_stb_o)
    else $error("bad write strobe");
endmodule
bind i2c_slave_register_port i2c_port_checker u_chk (.clk_i, .reset_i, .scl_i, .sda_i,
  .stall_i, .scl_oe_n_o, .sda_oe_n_o, .bus_busy_o, .wr_stb_o);
`default_nettype wire

// ---- test/bus_master_model.sv ----
// behavioural two-wire bus master on the far side of the port
`default_nettype none
module bus_master_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o,
  output var logic rd_stb_o,
  output var logic [7:0] rd_data_o,
  output var logic hang_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    rd_stb_o = 1'b0;
    rd_data_o = 8'h00;
    hang_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // release scl and wait for the wire; a stretching target holds it low
  task automatic hi;
    int k;
    k = 0;
    scl_o <= 1'b1;
    tk(1);
    while (scl_i !== 1'b1 && k < 2000) begin
      tk(1);
      k++;
    end
    if (k >= 2000) hang_o <= 1'b1;
    tk(7);
  endtask
  // one 32-cycle (160 ns) bit slot; faster than a real bus to keep runs short,
  // the port itself has no rate limit; sda moves with scl low
  task automatic slot(input logic b, output logic r);
    tk(4);
    sda_o <= b;
    tk(12);
    hi;
    r = sda_i;
    tk(8);
    scl_o <= 1'b0;
  endtask
  // b low gives a start (scl then falls), b high a stop (scl stays high)
  task automatic cond(input logic b);
    tk(4);
    sda_o <= ~b;
    tk(12);
    hi;
    sda_o <= b;
    tk(8);
    scl_o <= b;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], r);
    slot(1'b1, ack);
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    slot(nack, r);
    rd_data_o <= d;
    rd_stb_o <= 1'b1;
    tk(1);
    rd_stb_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/i2c_slave_register_port_bench.sv ----
// self-checking bench of the register port against a bus master model
`include "i2c_port_defs.vh"
`default_nettype none
module i2c_slave_register_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i, stall_i, sensor_valid_i, sel;
  logic [47:0] sensor_data_i;
  logic m_scl, m_sda, rd_stb, hang;
  logic [7:0] rd_data, dbyte;
  logic [7:0] store [0:255];
  logic [15:0] exp_q [$];
  int seed = 42187, n_fail = 0, cmp_count = 0;
  wire scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, bus_busy_o, wr_stb_o;
  wire [7:0] wr_addr_o, wr_data_o;
  // pulled-up open-drain wires: any party pulling low wins
  wire scl_i = m_scl & (scl_oe_n_o | scl_o);
  wire sda_i = m_sda & (sda_oe_n_o | sda_o);
  always #2.5 clk_i = ~clk_i;
  i2c_slave_register_port u_dut (.clk_i, .reset_i, .scl_i, .scl_o, .scl_oe_n_o, .sda_i,
    .sda_o, .sda_oe_n_o, .addr_lsb_select_pin_i(sel), .sensor_data_i, .sensor_valid_i,
    .stall_i, .bus_busy_o, .wr_stb_o, .wr_addr_o, .wr_data_o);
  bus_master_model u_m (.clk_i, .scl_i, .sda_i, .scl_o(m_scl), .sda_o(m_sda),
    .rd_stb_o(rd_stb), .rd_data_o(rd_data), .hang_o(hang));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // reference register map: what a read of each place must return
  function automatic logic [7:0] model(input logic [7:0] a);
    if (a == `REG_IDENTITY) return {1'b0, `ADDR_UPPER6, sel};
    if (a >= `REG_SENS_BASE && a < `REG_SENS_BASE + `SENS_BYTES)
      return sensor_data_i[47 - 8 * (a - `REG_SENS_BASE) -: 8];
    if (a >= `REG_RW_BASE && a < `REG_RW_BASE + 8'h10) return store[a];
    return 8'h00;
  endfunction
  task automatic put(input logic [7:0] b, input logic nack);
    logic a;
    u_m.send(b, a);
    check({15'h0, a}, {15'h0, nack});
  endtask
  task automatic open_ptr(input logic [7:0] p);
    u_m.cond(1'b0);
    put({`ADDR_UPPER6, sel, 1'b0}, 1'b0);
    put(p, 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input int n);
    logic [7:0] a, d;
    open_ptr(p);
    for (int i = 0; i < n; i++) begin
      a = p + i[7:0];
      d = 8'($random(seed));
      exp_q.push_back({a, d});
      if (a >= `REG_RW_BASE && a < `REG_RW_BASE + 8'h10) store[a] = d;
      put(d, 1'b0);
    end
    u_m.cond(1'b1);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    open_ptr(p);
    u_m.cond(1'b0);
    put({`ADDR_UPPER6, sel, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({8'h00, model(p + i[7:0])});
      u_m.recv(i == n - 1, dbyte);
    end
    u_m.cond(1'b1);
  endtask
  // results are matched in order against the notes the drivers left
  always @(posedge clk_i) begin
    if (wr_stb_o === 1'b1 || rd_stb === 1'b1) begin
      logic [15:0] v;
      v = (wr_stb_o === 1'b1) ? {wr_addr_o, wr_data_o} : {8'h00, rd_data};
      if (exp_q.size() == 0) check(v, ~v);
      else check(v, exp_q.pop_front());
    end
  end
  always @(posedge hang) begin
    n_fail++;
    end_of_test;
  end
  initial begin
    reset_i = 1'b1;
    stall_i = 1'b0;
    sensor_valid_i = 1'b0;
    sel = 1'b0;
    sensor_data_i = 48'h0;
    foreach (store[i]) store[i] = 8'h00;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    sensor_data_i <= 48'({$random(seed), $random(seed)});
    sensor_valid_i <= 1'b1;
    @(posedge clk_i);
    sensor_valid_i <= 1'b0;
    // stall inside the pointer byte (no stretch is allowed during the address)
    // so the master has to wait out a stretch
    fork
      wr(8'h20, 3);
      begin
        repeat (400) @(posedge clk_i);
        stall_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        stall_i <= 1'b0;
      end
    join
    rd(8'h20, 3);
    wr(`REG_SENS_BASE, 2);
    rd(`REG_SENS_BASE, 6);
    for (int p = 0; p < 2; p++) begin
      sel <= p[0];
      repeat (8) @(posedge clk_i);
      rd(`REG_IDENTITY, 1);
    end
    // repeated start to another target: no ack, nothing stored
    open_ptr(8'h20);
    u_m.cond(1'b0);
    put({`ADDR_UPPER6, ~sel, 1'b0}, 1'b1);
    put(8'h5a, 1'b1);
    u_m.cond(1'b1);
    rd(8'h20, 1);
    end_of_test;
  end
endmodule
`default_nettype wire
